/* File: logic/fault_summary_status.sv */
// Fault summary status register of a dual-channel high-side switch
`timescale 1ns/1ns
module fault_summary_status (
  input wire logic clk,
  input wire logic reset_n,
  input wire fault_summary_pkg::reg_access_t reg_access,
  input wire fault_summary_pkg::chan_fault_t chan1_faults,
  input wire fault_summary_pkg::chan_fault_t chan2_faults,
  input wire fault_summary_pkg::supply_cond_t supply_async,
  input wire logic fault_latch_select,
  input wire logic serial_err_mask,
  input wire logic fallback_mode_flag,
  input wire logic serial_frame_error,
  input wire logic link_watchdog_enable,
  input wire logic link_timeout_event,
  output logic [15:0] read_data_r,
  output logic fault_pin_request_r,
  output logic [15:0] status_value
);

  // ----------------------------------------
  // Condition gathering
  // ----------------------------------------
  fault_summary_pkg::supply_cond_t supply_s;
  logic [fault_summary_pkg::CHAN_FAULTS:0] sum_cond;
  logic [fault_summary_pkg::CHAN_FAULTS:0] sum_q;
  logic sum_clear;
  logic [7:0] glob_set;
  logic [7:0] glob_cond;
  logic [7:0] glob_clear;
  logic [7:0] glob_q;
  logic [7:0] glob_nxt;
  logic summary_nxt;
  logic summary_q;
  logic summary_clear;
  logic serial_err_seen;
  logic [15:0] status;
  logic [15:0] read_data_nxt;
  logic fault_pin_nxt;

  // Supply comparators are analogue and asynchronous to the core clock
  level_sync #(
    .WIDTH(fault_summary_pkg::SUPPLY_CONDS)
  ) u_supply_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(supply_async),
    .level_out(supply_s)
  );

  // Channel causes OR across both channels, supply cause below them
  always_comb begin
    sum_cond = {chan1_faults | chan2_faults,
                supply_s.logic_supply_low | supply_s.battery_undervoltage};
  end

  // Without latching, clearing every cycle makes the bits follow their causes
  assign sum_clear = reg_access.read_channel | ~fault_latch_select;

  // ----------------------------------------
  // Channel and supply summary bits 15..9
  // ----------------------------------------
  // Each bit set wins over a channel-status read that lands the same cycle
  for (genvar i = 0; i <= fault_summary_pkg::CHAN_FAULTS; i++) begin : g_sum
    sticky_flag #(
      .RESET_VAL(fault_summary_pkg::STATUS_RESET[fault_summary_pkg::BIT_SUPPLY_SUMMARY + i])
    ) u_flag (
      .clk(clk),
      .reset_n(reset_n),
      .set_in(sum_cond[i]),
      .cond_in(sum_cond[i]),
      .clear_in(sum_clear),
      .flag_nxt(),
      .flag_r(sum_q[i])
    );
  end

  // ----------------------------------------
  // Global flags 7..0
  // ----------------------------------------
  assign serial_err_seen = serial_frame_error & ~serial_err_mask;

  // Sources, causes and clears per global bit; bit 5 has none
  always_comb begin
    glob_set = '0;
    glob_cond = '0;
    glob_clear = {8{reg_access.read_global}};
    glob_set[fault_summary_pkg::BIT_FALLBACK] = fallback_mode_flag;
    glob_cond[fault_summary_pkg::BIT_FALLBACK] = fallback_mode_flag;
    glob_clear[fault_summary_pkg::BIT_FALLBACK] =
      reg_access.write_global & reg_access.write_data[fault_summary_pkg::BIT_FALLBACK];
    glob_set[fault_summary_pkg::BIT_SERIAL_ERR] = serial_err_seen;
    glob_cond[fault_summary_pkg::BIT_SERIAL_ERR] = serial_err_seen;
    glob_set[fault_summary_pkg::BIT_LINK_TIMEOUT] = link_watchdog_enable & link_timeout_event;
    glob_cond[fault_summary_pkg::BIT_LINK_TIMEOUT] = link_watchdog_enable & link_timeout_event;
    glob_set[fault_summary_pkg::BIT_LOGIC_LOW] = supply_s.logic_supply_low;
    glob_cond[fault_summary_pkg::BIT_LOGIC_LOW] = supply_s.logic_supply_low;
    glob_set[fault_summary_pkg::BIT_BATT_WARN] = supply_s.battery_low_warning;
    glob_cond[fault_summary_pkg::BIT_BATT_WARN] = supply_s.battery_low_warning;
    glob_set[fault_summary_pkg::BIT_BATT_UV] = supply_s.battery_undervoltage;
    glob_cond[fault_summary_pkg::BIT_BATT_UV] = supply_s.battery_undervoltage;
  end

  // Power-on flag has no cause after reset, so any global read clears it
  for (genvar i = 0; i < 8; i++) begin : g_glob
    if (i == fault_summary_pkg::BIT_RESERVED) begin : g_rsv
      assign glob_q[i] = 1'b0;
      assign glob_nxt[i] = 1'b0;
    end else begin : g_bit
      sticky_flag #(
        .RESET_VAL(fault_summary_pkg::STATUS_RESET[i])
      ) u_flag (
        .clk(clk),
        .reset_n(reset_n),
        .set_in(glob_set[i]),
        .cond_in(glob_cond[i]),
        .clear_in(glob_clear[i]),
        .flag_nxt(glob_nxt[i]),
        .flag_r(glob_q[i])
      );
    end
  end

  // ----------------------------------------
  // Global summary bit 8
  // ----------------------------------------
  // Looks at next values so one read clears bit 8 together with its sources
  assign summary_nxt = |glob_nxt;
  assign summary_clear = reg_access.read_global | ~fault_latch_select;

  sticky_flag #(
    .RESET_VAL(fault_summary_pkg::STATUS_RESET[fault_summary_pkg::BIT_GLOBAL_SUMMARY])
  ) u_summary (
    .clk(clk),
    .reset_n(reset_n),
    .set_in(summary_nxt),
    .cond_in(summary_nxt),
    .clear_in(summary_clear),
    .flag_nxt(),
    .flag_r(summary_q)
  );

  // ----------------------------------------
  // Read path and fault pin request
  // ----------------------------------------
  // Writes touch only bit 7; every other bit ignores write data
  assign status = {sum_q, summary_q, glob_q};
  assign status_value = status;

  // Read data is the value before the read's own clearing takes effect
  always_comb begin
    read_data_nxt = read_data_r;
    if (reg_access.read_global) begin
      read_data_nxt = status;
    end
    fault_pin_nxt = |status;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      read_data_r <= '0;
      fault_pin_request_r <= 1'b0;
    end else begin
      read_data_r <= read_data_nxt;
      fault_pin_request_r <= fault_pin_nxt;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n)
    status[fault_summary_pkg::BIT_RESERVED] == 1'b0)
    else $error("Reserved bit reads nonzero");

  a_wire_heat_set: assert property (@(posedge clk) disable iff (!reset_n)
    (chan1_faults.wire_heating_fault || chan2_faults.wire_heating_fault) |=> status[15])
    else $error("Wire heating fault not shown");

  a_lpm_exit_set: assert property (@(posedge clk) disable iff (!reset_n)
    chan2_faults.low_power_exit_fault |=> status[14])
    else $error("Low power exit fault not shown");

  a_live_follow: assert property (@(posedge clk) disable iff (!reset_n)
    (!fault_latch_select && !chan1_faults.overcurrent_fault && !chan2_faults.overcurrent_fault)
    |=> !status[12])
    else $error("Unlatched overcurrent bit did not follow cause");

  a_latch_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (fault_latch_select && status[13] && !reg_access.read_channel) |=> status[13])
    else $error("Latched thermal bit dropped without read");

  a_latch_clear: assert property (@(posedge clk) disable iff (!reset_n)
    (reg_access.read_channel && !chan1_faults.open_load_fault && !chan2_faults.open_load_fault)
    |=> !status[10])
    else $error("Open load bit not cleared by channel read");

  a_supply_sum: assert property (@(posedge clk) disable iff (!reset_n)
    supply_s.battery_undervoltage |=> status[9] && status[0])
    else $error("Supply undervoltage not shown");

  a_global_sum: assert property (@(posedge clk) disable iff (!reset_n)
    (|status[7:0]) |-> status[8])
    else $error("Global summary missing");

  a_fallback_w1c: assert property (@(posedge clk) disable iff (!reset_n)
    (reg_access.write_global && reg_access.write_data[7] && !fallback_mode_flag) |=> !status[7])
    else $error("Fallback flag not cleared by write one");

  a_por_clear: assert property (@(posedge clk) disable iff (!reset_n)
    reg_access.read_global |=> !status[6] ##1 !status[6])
    else $error("Power-on flag survived a read");

  a_serial_mask: assert property (@(posedge clk) disable iff (!reset_n)
    (serial_err_mask && !status[4]) |=> !status[4])
    else $error("Masked serial error set the flag");

  a_serial_set: assert property (@(posedge clk) disable iff (!reset_n)
    (serial_frame_error && !serial_err_mask) |=> status[4])
    else $error("Serial error not latched");

  a_timeout_set: assert property (@(posedge clk) disable iff (!reset_n)
    (link_watchdog_enable && link_timeout_event) |=> status[3])
    else $error("Link timeout not latched");

  a_read_keeps: assert property (@(posedge clk) disable iff (!reset_n)
    (reg_access.read_global && supply_s.logic_supply_low) |=> status[2])
    else $error("Flag with live cause cleared by read");

  a_read_data: assert property (@(posedge clk) disable iff (!reset_n)
    reg_access.read_global |=> read_data_r == $past(status))
    else $error("Read data does not match status");

  a_thermal_set: assert property (@(posedge clk) disable iff (!reset_n)
    (chan1_faults.thermal_shutdown_fault || chan2_faults.thermal_shutdown_fault) |=> status[13])
    else $error("Thermal shutdown fault not shown");

  a_overcurrent_set: assert property (@(posedge clk) disable iff (!reset_n)
    (chan1_faults.overcurrent_fault || chan2_faults.overcurrent_fault) |=> status[12])
    else $error("Overcurrent fault not shown");

  a_short_set: assert property (@(posedge clk) disable iff (!reset_n)
    (chan1_faults.battery_short_fault || chan2_faults.battery_short_fault) |=> status[11])
    else $error("Battery short fault not shown");

  a_open_load_set: assert property (@(posedge clk) disable iff (!reset_n)
    (chan1_faults.open_load_fault || chan2_faults.open_load_fault) |=> status[10])
    else $error("Open load fault not shown");

  a_logic_low_set: assert property (@(posedge clk) disable iff (!reset_n)
    supply_s.logic_supply_low |=> status[2] && status[9])
    else $error("Logic supply low not shown");

  a_batt_warn_set: assert property (@(posedge clk) disable iff (!reset_n)
    supply_s.battery_low_warning |=> status[1])
    else $error("Battery low warning not shown");

  a_uv_clear: assert property (@(posedge clk) disable iff (!reset_n)
    (reg_access.read_global && !supply_s.battery_undervoltage) |=> !status[0])
    else $error("Battery undervoltage flag survived a read with cause gone");

  a_fallback_set: assert property (@(posedge clk) disable iff (!reset_n)
    fallback_mode_flag |=> status[7])
    else $error("Fallback mode not shown");

  a_write_ignored: assert property (@(posedge clk) disable iff (!reset_n)
    (reg_access.write_global && !reg_access.read_global) |=> status[6] == $past(status[6]))
    else $error("Write changed the power-on flag");

  a_summary_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (fault_latch_select && status[8] && !reg_access.read_global) |=> status[8])
    else $error("Latched summary dropped without read");

  c_por_read: cover property (@(posedge clk) disable iff (!reset_n)
    status[6] ##1 reg_access.read_global ##1 !status[6]);
  c_latched_clear: cover property (@(posedge clk) disable iff (!reset_n)
    fault_latch_select && status[12] ##1 reg_access.read_channel ##1 !status[12]);
  c_fallback_clear: cover property (@(posedge clk) disable iff (!reset_n)
    status[7] ##1 reg_access.write_global ##1 !status[7]);
  c_serial_masked: cover property (@(posedge clk) disable iff (!reset_n)
    serial_frame_error && serial_err_mask);
  c_unlatched_follow: cover property (@(posedge clk) disable iff (!reset_n)
    !fault_latch_select && (|status[15:10]) ##1 !fault_latch_select && !(|status[15:10]));

endmodule

/* File: logic/fault_summary_pkg.sv */
// Shared constants and carrier types for the fault summary status register
package fault_summary_pkg;

  // ----------------------------------------
  // Register layout
  // ----------------------------------------
  localparam int STATUS_W = 16;
  localparam logic [15:0] STATUS_RESET = 16'h0347;
  localparam int BIT_WIRE_HEATING = 15;
  localparam int BIT_LOW_POWER_EXIT = 14;
  localparam int BIT_THERMAL = 13;
  localparam int BIT_OVERCURRENT = 12;
  localparam int BIT_BATTERY_SHORT = 11;
  localparam int BIT_OPEN_LOAD = 10;
  localparam int BIT_SUPPLY_SUMMARY = 9;
  localparam int BIT_GLOBAL_SUMMARY = 8;
  localparam int BIT_FALLBACK = 7;
  localparam int BIT_POWER_ON = 6;
  localparam int BIT_RESERVED = 5;
  localparam int BIT_SERIAL_ERR = 4;
  localparam int BIT_LINK_TIMEOUT = 3;
  localparam int BIT_LOGIC_LOW = 2;
  localparam int BIT_BATT_WARN = 1;
  localparam int BIT_BATT_UV = 0;
  localparam int CHAN_FAULTS = 6;
  localparam int SUPPLY_CONDS = 3;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  // Field order matches bits 15 down to 10
  typedef struct packed {
    logic wire_heating_fault;
    logic low_power_exit_fault;
    logic thermal_shutdown_fault;
    logic overcurrent_fault;
    logic battery_short_fault;
    logic open_load_fault;
  } chan_fault_t;

  // Field order matches bits 2 down to 0
  typedef struct packed {
    logic logic_supply_low;
    logic battery_low_warning;
    logic battery_undervoltage;
  } supply_cond_t;

  typedef struct packed {
    logic read_global;
    logic read_channel;
    logic write_global;
    logic [15:0] write_data;
  } reg_access_t;

endpackage

/* File: logic/level_sync.sv */
// Three-stage synchroniser with agreement filter for asynchronous levels
`timescale 1ns/1ns
module level_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;
  logic [WIDTH-1:0] level_r;
  logic [WIDTH-1:0] level_nxt;

  // A change is accepted only once stages two and three agree
  always_comb begin
    level_nxt = level_r;
    for (int i = 0; i < WIDTH; i++) begin
      if (stage2_r[i] == stage3_r[i]) begin
        level_nxt[i] = stage3_r[i];
      end
    end
  end

  // Stage one feeds stage two only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
      level_r <= '0;
    end else begin
      meta_r <= async_in;
      stage2_r <= meta_r;
      stage3_r <= stage2_r;
      level_r <= level_nxt;
    end
  end

  assign level_out = level_r;

endmodule

/* File: logic/sticky_flag.sv */
// One status flag: set by an event, held until cleared with its cause gone
`timescale 1ns/1ns
module sticky_flag #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic set_in,
  input wire logic cond_in,
  input wire logic clear_in,
  output logic flag_nxt,
  output logic flag_r
);

  // Set beats clear; a clear is refused while the cause is still present
  always_comb begin
    flag_nxt = set_in | (flag_r & ~(clear_in & ~cond_in));
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_r <= RESET_VAL;
    end else begin
      flag_r <= flag_nxt;
    end
  end

endmodule

/* File: tb/host_model.sv */
// Host-side partner that issues register accesses as one-cycle strobes
`timescale 1ns/1ns
module host_model (
  input wire logic clk,
  output fault_summary_pkg::reg_access_t acc
);
  initial acc = '0;

  // ----------------------------------------
  // Access strobes
  // ----------------------------------------
  // Kind 0 reads this register, 1 reads a channel register, 2 writes this register
  // A random idle gap makes the host answer sometimes promptly, sometimes slowly
  task automatic pulse(input int kind, input logic [15:0] data);
    repeat ($urandom_range(1, 3)) @(posedge clk);
    acc.write_data <= data;
    acc.read_global <= (kind == 0);
    acc.read_channel <= (kind == 1);
    acc.write_global <= (kind == 2);
    @(posedge clk);
    acc <= '0;
  endtask
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the fault summary status register
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  fault_summary_pkg::reg_access_t reg_access;
  fault_summary_pkg::chan_fault_t chan1_faults = '0;
  fault_summary_pkg::chan_fault_t chan2_faults = '0;
  fault_summary_pkg::chan_fault_t f;
  fault_summary_pkg::supply_cond_t supply_async = '0;
  fault_summary_pkg::supply_cond_t cond;
  logic fault_latch_select = 1'b1;
  logic serial_err_mask = 1'b0;
  logic fallback_mode_flag = 1'b0;
  logic serial_frame_error = 1'b0;
  logic link_watchdog_enable = 1'b0;
  logic link_timeout_event = 1'b0;
  logic [15:0] read_data_r;
  logic fault_pin_request_r;
  logic [15:0] status_value;
  logic [15:0] exp;
  logic [15:0] expect_q[$];
  logic read_seen = 1'b0;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;

  // ----------------------------------------
  // Clock, design and partner
  // ----------------------------------------
  always #2 clk = ~clk;

  fault_summary_status i_fault_summary_status (.clk(clk), .reset_n(reset_n), .reg_access(reg_access),
    .chan1_faults(chan1_faults), .chan2_faults(chan2_faults), .supply_async(supply_async),
    .fault_latch_select(fault_latch_select), .serial_err_mask(serial_err_mask),
    .fallback_mode_flag(fallback_mode_flag), .serial_frame_error(serial_frame_error),
    .link_watchdog_enable(link_watchdog_enable), .link_timeout_event(link_timeout_event),
    .read_data_r(read_data_r), .fault_pin_request_r(fault_pin_request_r), .status_value(status_value));

  host_model host (.clk(clk), .acc(reg_access));

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] expv);
    tests_run++;
    if (seen !== expv) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, expv, seen);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Note the expected word, then let the host read; the monitor compares
  task automatic rd(input logic [15:0] expv);
    expect_q.push_back(expv);
    host.pulse(0, 16'h0000);
    repeat (2) @(posedge clk);
  endtask

  // Read data lands on the edge that takes the strobe, so look one edge later
  always @(posedge clk) begin
    read_seen <= reg_access.read_global;
    if (read_seen) begin
      if (expect_q.size() > 0) begin
        check("read_data_r", read_data_r, expect_q.pop_front());
      end else begin
        check("unexpected read", read_data_r, 16'hxxxx);
      end
    end
  end

  // Cut a hang short; the run needs well under this many cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      summarize();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h4d7cb86b));
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    // Reset word, then read-clear of the power-on and supply flags
    rd(16'h0347);
    host.pulse(2, 16'hff7f);
    rd(16'h0200);
    check("fault_pin_request_r", {15'h0, fault_pin_request_r}, 16'h0001);
    host.pulse(1, 16'h0000);
    rd(16'h0000);
    check("fault_pin_request_r", {15'h0, fault_pin_request_r}, 16'h0000);
    $display("test reset_values done");
    // Each channel cause from a random channel; a channel read while it lasts is refused
    for (int i = 0; i < 6; i++) begin
      f = fault_summary_pkg::chan_fault_t'(6'(1 << i));
      if ($urandom_range(0, 1) == 1) chan2_faults <= f;
      else chan1_faults <= f;
      host.pulse(1, 16'h0000);
      @(posedge clk);
      chan1_faults <= '0;
      chan2_faults <= '0;
      rd({f, 10'h000});
      host.pulse(1, 16'h0000);
      rd(16'h0000);
    end
    $display("test channel_faults done");
    // Fallback: write-one-clear refused while the mode lasts, accepted after
    fallback_mode_flag <= 1'b1;
    host.pulse(2, 16'h0080);
    rd(16'h0180);
    fallback_mode_flag <= 1'b0;
    host.pulse(2, 16'($urandom()) | 16'h0080);
    rd(16'h0100);
    rd(16'h0000);
    $display("test fallback done");
    // Serial error masked and not, link timeout with watchdog off and on
    for (int k = 0; k < 4; k++) begin
      serial_err_mask <= (k == 0);
      link_watchdog_enable <= (k == 3);
      @(posedge clk);
      serial_frame_error <= (k < 2);
      link_timeout_event <= (k >= 2);
      @(posedge clk);
      serial_frame_error <= 1'b0;
      link_timeout_event <= 1'b0;
      repeat (3) @(posedge clk);
      exp = (k == 1) ? 16'h0110 : ((k == 3) ? 16'h0108 : 16'h0000);
      check("fault_pin_request_r", {15'h0, fault_pin_request_r}, {15'h0, exp != 16'h0});
      rd(exp);
      rd(16'h0000);
    end
    $display("test serial_link done");
    // Supply conditions pass a synchroniser, so allow generous settling
    for (int s = 0; s < 3; s++) begin
      cond = fault_summary_pkg::supply_cond_t'(3'(1 << s));
      exp = {6'h00, cond.logic_supply_low | cond.battery_undervoltage, 1'b1, 5'h00, cond};
      supply_async <= cond;
      repeat (8) @(posedge clk);
      rd(exp);
      rd(exp);
      supply_async <= '0;
      repeat (8) @(posedge clk);
      rd(exp);
      rd({6'h00, exp[9], 9'h000});
      host.pulse(1, 16'h0000);
      rd(16'h0000);
    end
    $display("test supply done");
    // Without latching the channel bits follow their causes one edge later
    fault_latch_select <= 1'b0;
    f = fault_summary_pkg::chan_fault_t'(6'(1 << $urandom_range(0, 5)));
    chan2_faults <= f;
    repeat (2) @(posedge clk);
    check("status_value", status_value, {f, 10'h000});
    chan2_faults <= '0;
    repeat (2) @(posedge clk);
    check("status_value", status_value, 16'h0000);
    fault_latch_select <= 1'b1;
    $display("test unlatched done");
    // A second reset in mid-run must bring back the power-up word
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    check("status_value", status_value, fault_summary_pkg::STATUS_RESET);
    reset_n <= 1'b1;
    rd(fault_summary_pkg::STATUS_RESET);
    $display("test second_reset done");
    summarize();
  end
endmodule
